// ### pmrc_core.sv
// power mode and reset control with apb register access
`timescale 1ns/1ps
// Function
// - stop bit enters stop after instruction retires
// - stop halts oscillator, cpu, digital peripherals
// - stop ends only by reset, vector zero
// - missing clock detector reset ends stop
// - suspend bit halts cpu and oscillator
// - port match stays active during suspend
// - suspend ends on match, comparator, reset
// - wake interrupt serviced right after wake
// - stop and idle bits read zero
// - bits 7:2 are scratch flags
// - reset halts cpu, disables interrupts, timers
// - reset keeps data memory, resets stack
// - port latches 0xff open drain, pullups on
// - supply or power-on reset drives pin low
// - reset exit: pc zero, internal osc, watchdog
// - power-on sets flag, others clear it
// - of the resets, only power-on enables supply monitor
// - supply low holds reset, no delay
// - flash op without high monitor resets
// - high threshold uncalibrated reset stays held
// - threshold select low 0, high 1
// - missing clock flag bit enables detector
module pmrc_core
  import pmrc_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  input  wire logic               power_on_event,
  input  wire logic               supply_below_threshold,
  input  wire logic               regulator_calibrated,
  input  wire logic               missing_clock_event,
  input  wire logic               other_reset_event,
  input  wire logic               instr_retire,
  input  wire logic               flash_op,
  input  pmrc_pkg::pmrc_wake_t    wake_in,
  input  wire logic               wake_irq_enabled,
  output logic                    cpu_clk_en,
  output logic                    periph_clk_en,
  output logic                    int_osc_en,
  output logic                    port_match_en,
  output logic                    system_reset,
  output logic                    reset_pin_out,
  output logic                    reset_pin_oe,
  output logic [7:0]              port_latch,
  output logic                    port_open_drain,
  output logic                    weak_pullup_en,
  output logic                    irq_service_req,
  output logic                    watchdog_en,
  output logic [3:0]              watchdog_div,
  output logic                    int_osc_select,
  output logic [15:0]             pc_load_value,
  output logic                    sp_reinit,
  output logic                    mcd_enable
);
  import pmrc_pkg::*;

  pmrc_state_t state;
  pmrc_state_t next_state;
  logic [5:0]  scratch_flags;
  logic [5:0]  next_scratch_flags;
  logic        pend_idle, pend_stop, pend_susp;
  logic        next_pend_idle, next_pend_stop, next_pend_susp;
  logic        mon_en, thresh_high, por_flag, mcd_flag, mcd_en, fe_flag, ztc_en, cmp_wake_en;
  logic        next_mon_en, next_thresh_high, next_por_flag, next_mcd_flag, next_mcd_en;
  logic        next_fe_flag, next_ztc_en, next_cmp_wake_en;
  logic        por_seen, next_por_seen, pin_drive, next_pin_drive, irq_req, next_irq_req;
  logic [2:0]  seq_cnt, next_seq_cnt;
  logic        wr_acc;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        mapped;
  logic        flash_err;
  logic        any_reset;
  logic        hold_reset;

  // apb writes land only in the access phase, zero wait
  assign wr_acc  = psel && penable && pwrite && pstrb[0];
  assign mapped  = (paddr == PMRC_ADDR_POWER_CONTROL) || (paddr == PMRC_ADDR_OSC_CONTROL) ||
                   (paddr == PMRC_ADDR_SUPPLY_MONITOR) || (paddr == PMRC_ADDR_RESET_SOURCE) ||
                   (paddr == PMRC_ADDR_VREF_CONTROL) || (paddr == PMRC_ADDR_STATUS) ||
                   (paddr == PMRC_ADDR_WAKE_CONTROL);
  assign flash_err = flash_op && !(mon_en && thresh_high) && (state == PMRC_RUN);
  // missing clock only counts when the detector is armed
  assign any_reset = power_on_event || (supply_below_threshold && mon_en) ||
                     (missing_clock_event && mcd_en) || flash_err || other_reset_event;
  // a high threshold with an uncalibrated regulator keeps us parked
  assign hold_reset = (supply_below_threshold && mon_en) ||
                      (thresh_high && !regulator_calibrated && !por_seen);

  // register and state next values
  always_comb
  begin
    next_state         = state;
    next_scratch_flags = scratch_flags;
    next_pend_idle     = pend_idle;
    next_pend_stop     = pend_stop;
    next_pend_susp     = pend_susp;
    next_mon_en        = mon_en;
    next_thresh_high   = thresh_high;
    next_por_flag      = por_flag;
    next_mcd_flag      = mcd_flag;
    next_mcd_en        = mcd_en;
    next_fe_flag       = fe_flag;
    next_ztc_en        = ztc_en;
    next_cmp_wake_en   = cmp_wake_en;
    next_por_seen      = por_seen;
    next_pin_drive     = pin_drive;
    next_irq_req       = 1'b0;
    next_seq_cnt       = seq_cnt;
    if (wr_acc && state == PMRC_RUN)
    begin
      case (paddr)
        PMRC_ADDR_POWER_CONTROL:
        begin
          next_scratch_flags = pwdata[7:2];
          next_pend_idle     = pwdata[PMRC_BIT_IDLE];
          next_pend_stop     = pwdata[PMRC_BIT_STOP];
        end
        PMRC_ADDR_OSC_CONTROL: next_pend_susp = pwdata[PMRC_BIT_SUSPEND];
        PMRC_ADDR_SUPPLY_MONITOR:
        begin
          next_mon_en      = pwdata[PMRC_BIT_MON_EN];
          next_thresh_high = pwdata[PMRC_BIT_THRESH];
        end
        PMRC_ADDR_RESET_SOURCE: next_mcd_en = pwdata[PMRC_BIT_MCDF];
        PMRC_ADDR_VREF_CONTROL: next_ztc_en = pwdata[PMRC_BIT_ZTC];
        PMRC_ADDR_WAKE_CONTROL: next_cmp_wake_en = pwdata[PMRC_BIT_CMP_WAKE];
        default: ;
      endcase
    end
    case (state)
      PMRC_RUN:
      begin
        // entry waits for the writing instruction to retire
        if (instr_retire && pend_stop)
        begin
          next_state     = PMRC_STOP_ST;
          next_pend_stop = 1'b0;
        end
        else if (instr_retire && pend_susp)
        begin
          next_state     = PMRC_SUSP_ST;
          next_pend_susp = 1'b0;
        end
        else if (instr_retire && pend_idle)
        begin
          next_state     = PMRC_IDLE_ST;
          next_pend_idle = 1'b0;
        end
      end
      PMRC_IDLE_ST:
        if (wake_in.interrupt)
        begin
          next_state   = PMRC_RUN;
          next_irq_req = 1'b1;
        end
      PMRC_STOP_ST: ;  // only a reset leaves stop
      PMRC_SUSP_ST:
        if (wake_in.port_match || (wake_in.comparator_low && cmp_wake_en))
        begin
          next_state   = PMRC_RUN;
          next_irq_req = wake_irq_enabled;
        end
      PMRC_RESET_ST:
        if (!any_reset && !hold_reset)
        begin
          if (seq_cnt == 3'(PMRC_SEQ_CYCLES - 1) || !por_seen)  // no por delay otherwise
          begin
            next_state     = PMRC_RUN;
            next_pin_drive = 1'b0;
          end
          else
            next_seq_cnt = seq_cnt + 3'd1;
        end
      default: next_state = PMRC_RESET_ST;
    endcase
    // reset entry overrides the next state, pending requests drop
    if (any_reset || (state == PMRC_RESET_ST && hold_reset))
    begin
      next_state     = PMRC_RESET_ST;
      next_seq_cnt   = 3'd0;
      next_pend_idle = 1'b0;
      next_pend_stop = 1'b0;
      next_pend_susp = 1'b0;
      next_scratch_flags = 6'h00;
      next_thresh_high   = power_on_event ? 1'b0 : thresh_high;
      next_pin_drive = power_on_event || (supply_below_threshold && mon_en) ? 1'b1 : pin_drive;
    end
    if (any_reset)
    begin
      next_por_seen = power_on_event;
      next_por_flag = power_on_event;
      next_mcd_flag = missing_clock_event && mcd_en;
      next_fe_flag  = flash_err;
      if (power_on_event)
      begin
        next_mon_en = 1'b1;
        next_mcd_en = 1'b0;
      end
    end
    else if (wr_acc && paddr == PMRC_ADDR_RESET_SOURCE && state == PMRC_RUN && pwdata[PMRC_BIT_PORF])
      next_por_flag = por_flag;  // selecting the monitor as source leaves flag
  end

  // apb read data, registered for one-cycle answer
  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && !penable)
    begin
      next_pslverr = !mapped;
      case (paddr)
        PMRC_ADDR_POWER_CONTROL:  next_prdata[7:0] = {scratch_flags, 2'b00};
        PMRC_ADDR_OSC_CONTROL:    next_prdata[PMRC_BIT_SUSPEND] = pend_susp;
        PMRC_ADDR_SUPPLY_MONITOR:
        begin
          next_prdata[PMRC_BIT_MON_EN]   = mon_en;
          next_prdata[PMRC_BIT_MON_STAT] = !supply_below_threshold;
          next_prdata[PMRC_BIT_THRESH]   = thresh_high;
        end
        PMRC_ADDR_RESET_SOURCE:
        begin
          next_prdata[PMRC_BIT_PORF]     = por_flag;
          next_prdata[PMRC_BIT_MCDF]     = mcd_flag;
          next_prdata[PMRC_BIT_FLASHERR] = fe_flag;
        end
        PMRC_ADDR_VREF_CONTROL:   next_prdata[PMRC_BIT_ZTC] = ztc_en;
        PMRC_ADDR_STATUS:         next_prdata[2:0] = state;
        PMRC_ADDR_WAKE_CONTROL:   next_prdata[PMRC_BIT_CMP_WAKE] = cmp_wake_en;
        default: ;
      endcase
    end
  end

  // registers; power-on comes up in reset with monitor enabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state         <= PMRC_RESET_ST;
      scratch_flags <= 6'h00;
      pend_idle     <= 1'b0;
      pend_stop     <= 1'b0;
      pend_susp     <= 1'b0;
      mon_en        <= 1'b1;
      thresh_high   <= 1'b0;
      por_flag      <= 1'b1;
      mcd_flag      <= 1'b0;
      mcd_en        <= 1'b0;
      fe_flag       <= 1'b0;
      ztc_en        <= 1'b0;
      cmp_wake_en   <= 1'b0;
      por_seen      <= 1'b1;
      pin_drive     <= 1'b1;
      irq_req       <= 1'b0;
      seq_cnt       <= 3'd0;
      prdata        <= 32'h0000_0000;
      pslverr       <= 1'b0;
      pready        <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      scratch_flags <= next_scratch_flags;
      pend_idle     <= next_pend_idle;
      pend_stop     <= next_pend_stop;
      pend_susp     <= next_pend_susp;
      mon_en        <= next_mon_en;
      thresh_high   <= next_thresh_high;
      por_flag      <= next_por_flag;
      mcd_flag      <= next_mcd_flag;
      mcd_en        <= next_mcd_en;
      fe_flag       <= next_fe_flag;
      ztc_en        <= next_ztc_en;
      cmp_wake_en   <= next_cmp_wake_en;
      por_seen      <= next_por_seen;
      pin_drive     <= next_pin_drive;
      irq_req       <= next_irq_req;
      seq_cnt       <= next_seq_cnt;
      prdata        <= (psel && !penable) ? next_prdata : prdata;
      pslverr       <= (psel && !penable) ? next_pslverr : pslverr;
      pready        <= psel && !penable;
    end
  end

  // clock gating and reset side outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_clk_en      <= 1'b0;
      periph_clk_en   <= 1'b0;
      int_osc_en      <= 1'b1;
      port_match_en   <= 1'b0;
      system_reset    <= 1'b1;
      reset_pin_out   <= 1'b0;
      reset_pin_oe    <= 1'b1;
      port_latch      <= PMRC_PORT_LATCH_RESET;
      port_open_drain <= 1'b1;
      weak_pullup_en  <= 1'b1;
      irq_service_req <= 1'b0;
      watchdog_en     <= 1'b0;
      watchdog_div    <= PMRC_WDT_DIV;
      int_osc_select  <= 1'b1;
      pc_load_value   <= PMRC_RESET_VECTOR;
      sp_reinit       <= 1'b1;
      mcd_enable      <= 1'b0;
    end
    else
    begin
      cpu_clk_en      <= next_state == PMRC_RUN;
      periph_clk_en   <= next_state == PMRC_RUN || next_state == PMRC_IDLE_ST;
      int_osc_en      <= next_state != PMRC_STOP_ST && next_state != PMRC_SUSP_ST;
      port_match_en   <= next_state == PMRC_SUSP_ST;
      system_reset    <= next_state == PMRC_RESET_ST;
      reset_pin_out   <= 1'b0;
      reset_pin_oe    <= next_pin_drive;
      port_latch      <= PMRC_PORT_LATCH_RESET;
      port_open_drain <= (next_state == PMRC_RESET_ST) ? 1'b1 : port_open_drain;
      weak_pullup_en  <= 1'b1;
      irq_service_req <= next_irq_req;
      watchdog_en     <= (next_state == PMRC_RESET_ST) ? 1'b0 : 1'b1;
      watchdog_div    <= PMRC_WDT_DIV;
      int_osc_select  <= (next_state == PMRC_RESET_ST) ? 1'b1 : int_osc_select;
      pc_load_value   <= PMRC_RESET_VECTOR;
      sp_reinit       <= next_state == PMRC_RESET_ST;
      mcd_enable      <= next_mcd_en;
    end
  end

  // properties
  property p_stop_entry;
    @(posedge pclk) disable iff (!presetn)
    (state == PMRC_RUN && pend_stop && instr_retire && !any_reset) |=> (state == PMRC_STOP_ST) ##1 !cpu_clk_en;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop not entered");
  property p_stop_clocks;
    @(posedge pclk) disable iff (!presetn)
    (state == PMRC_STOP_ST) |=> (!int_osc_en && !periph_clk_en) || system_reset;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("clocks run in stop");
  property p_stop_exit;
    @(posedge pclk) disable iff (!presetn)
    (state == PMRC_STOP_ST && !any_reset) |=> state == PMRC_STOP_ST;
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop left without reset");
  property p_mcd_reset;
    @(posedge pclk) disable iff (!presetn)
    (missing_clock_event && mcd_en) |=> state == PMRC_RESET_ST && system_reset;
  endproperty
  a_mcd_reset: assert property (p_mcd_reset) else $error("mcd did not reset");
  property p_susp_match;
    @(posedge pclk) disable iff (!presetn)
    (state == PMRC_SUSP_ST) |=> port_match_en || state != PMRC_SUSP_ST;
  endproperty
  a_susp_match: assert property (p_susp_match) else $error("port match off in suspend");
  property p_susp_wake;
    @(posedge pclk) disable iff (!presetn)
    (state == PMRC_SUSP_ST && wake_in.port_match && !any_reset) |=> state == PMRC_RUN ##1 cpu_clk_en;
  endproperty
  a_susp_wake: assert property (p_susp_wake) else $error("no wake on match");
  property p_por_flag;
    @(posedge pclk) disable iff (!presetn)
    (any_reset) |=> por_flag == $past(power_on_event);
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("por flag wrong");
  property p_flash_err;
    @(posedge pclk) disable iff (!presetn)
    flash_err |=> fe_flag && state == PMRC_RESET_ST;
  endproperty
  a_flash_err: assert property (p_flash_err) else $error("flash error no reset");
  property p_pin_low;
    @(posedge pclk) disable iff (!presetn)
    power_on_event |=> ##1 reset_pin_oe && !reset_pin_out;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("reset pin not driven");
  c_stop: cover property (@(posedge pclk) disable iff (!presetn) state == PMRC_STOP_ST ##1 state == PMRC_RESET_ST);
  c_susp: cover property (@(posedge pclk) disable iff (!presetn) state == PMRC_SUSP_ST ##1 state == PMRC_RUN);
  c_idle: cover property (@(posedge pclk) disable iff (!presetn) state == PMRC_IDLE_ST ##1 irq_service_req);
  c_ferr: cover property (@(posedge pclk) disable iff (!presetn) flash_err);
endmodule

// ### pmrc_core_test.sv
// self-checking testbench for the power mode and reset control block
`timescale 1ns/1ps
module pmrc_core_test;
  import pmrc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, watchdog_div;
  logic        power_on_event, supply_below_threshold, regulator_calibrated, missing_clock_event;
  logic        other_reset_event, instr_retire, flash_op, wake_irq_enabled;
  pmrc_wake_t  wake_in;
  logic        cpu_clk_en, periph_clk_en, int_osc_en, port_match_en, system_reset, reset_pin_out;
  logic        reset_pin_oe, port_open_drain, weak_pullup_en, irq_service_req, watchdog_en;
  logic        int_osc_select, sp_reinit, mcd_enable;
  logic [7:0]  port_latch;
  logic [15:0] pc_load_value;
  int          n_fail, comparisons, cycles;

  pmrc_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .power_on_event(power_on_event), .supply_below_threshold(supply_below_threshold),
    .regulator_calibrated(regulator_calibrated), .missing_clock_event(missing_clock_event),
    .other_reset_event(other_reset_event), .instr_retire(instr_retire), .flash_op(flash_op),
    .wake_in(wake_in), .wake_irq_enabled(wake_irq_enabled), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .int_osc_en(int_osc_en), .port_match_en(port_match_en),
    .system_reset(system_reset), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .port_latch(port_latch), .port_open_drain(port_open_drain), .weak_pullup_en(weak_pullup_en),
    .irq_service_req(irq_service_req), .watchdog_en(watchdog_en), .watchdog_div(watchdog_div),
    .int_osc_select(int_osc_select), .pc_load_value(pc_load_value), .sp_reinit(sp_reinit),
    .mcd_enable(mcd_enable));

  // free running 100 mhz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // no local limit here: the bench's cycle ceiling ends a hang
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    chk(32'(n), 32'h1);  // slave answers in the first access cycle
    #1;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // retire boundary, then let the mode change land
  task automatic retire;
    @(posedge pclk);
    instr_retire <= 1'b1;
    @(posedge pclk);
    instr_retire <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // 0 missing clock, 1 other reset, 2 flash op, 3 power on
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: missing_clock_event <= 1'b1;
      1: other_reset_event <= 1'b1;
      2: flash_op <= 1'b1;
      default: power_on_event <= 1'b1;
    endcase
    @(posedge pclk);
    missing_clock_event <= 1'b0;
    other_reset_event <= 1'b0;
    flash_op <= 1'b0;
    power_on_event <= 1'b0;
  endtask

  // bounded wait for reset entry (1) or running with cpu clock (0)
  // looks before the first edge: a reset without por delay lasts only one cycle
  task automatic wait_rst(input logic want);
    int n;
    n = 0;
    #1;
    while (!(want ? system_reset === 1'b1 : (system_reset === 1'b0 && cpu_clk_en === 1'b1)) && n < 60)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(n < 60), 32'h1);
  endtask

  initial
  begin
    {psel, penable, pwrite, presetn, power_on_event, supply_below_threshold} = '0;
    {missing_clock_event, other_reset_event, instr_retire, flash_op, wake_irq_enabled} = '0;
    {paddr, pwdata, cycles, n_fail, comparisons} = '0;
    regulator_calibrated = 1'b1;
    pstrb = 4'hf;
    wake_in = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(system_reset, 1'b1);
    chk(cpu_clk_en, 1'b0);
    chk(reset_pin_oe, 1'b1);
    chk({port_open_drain, weak_pullup_en, port_latch}, 32'h3ff);
    chk(sp_reinit, 1'b1);
    wait_rst(1'b0);
    chk({watchdog_en, int_osc_select, watchdog_div, pc_load_value}, 32'h3c0000);
    chk(weak_pullup_en, 1'b1);
    rchk(PMRC_ADDR_POWER_CONTROL, 32'hff, 32'h0);
    rchk(PMRC_ADDR_RESET_SOURCE, 32'h2, 32'h2);
    rchk(PMRC_ADDR_SUPPLY_MONITOR, 32'ha0, 32'h80);
    apb(1'b0, 12'h7f0, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    // stop entry with the detector armed; scratch bits kept, select bits read zero
    apb(1'b1, PMRC_ADDR_RESET_SOURCE, 32'h4);
    chk(mcd_enable, 1'b1);
    apb(1'b1, PMRC_ADDR_POWER_CONTROL, 32'haa);
    rchk(PMRC_ADDR_POWER_CONTROL, 32'hff, 32'ha8);
    chk(cpu_clk_en, 1'b1);
    retire();
    chk({cpu_clk_en, int_osc_en, periph_clk_en}, 32'h0);
    rchk(PMRC_ADDR_STATUS, 32'h7, 32'h2);
    wake_in.port_match <= 1'b1;
    repeat (10) @(posedge pclk);
    #1;
    chk(cpu_clk_en, 1'b0);
    wake_in.port_match <= 1'b0;
    pulse(0);
    wait_rst(1'b1);
    chk(reset_pin_oe, 1'b0);
    wait_rst(1'b0);
    rchk(PMRC_ADDR_RESET_SOURCE, 32'h6, 32'h4);
    rchk(PMRC_ADDR_POWER_CONTROL, 32'hff, 32'h0);
    // suspend, woken by a port match that asks for an interrupt
    apb(1'b1, PMRC_ADDR_VREF_CONTROL, 32'h8);
    wake_irq_enabled <= 1'b1;
    apb(1'b1, PMRC_ADDR_OSC_CONTROL, 32'h20);
    retire();
    chk({cpu_clk_en, int_osc_en, port_match_en}, 32'h1);
    rchk(PMRC_ADDR_STATUS, 32'h7, 32'h3);
    wake_in.port_match <= 1'b1;
    for (int n = 0; n < 20 && irq_service_req !== 1'b1; n++)
    begin
      @(posedge pclk);
      #1;
    end
    chk(irq_service_req, 1'b1);
    chk(system_reset, 1'b0);
    wake_in.port_match <= 1'b0;
    wake_irq_enabled <= 1'b0;
    // suspend again, woken by the comparator
    apb(1'b1, PMRC_ADDR_WAKE_CONTROL, 32'h1);
    apb(1'b1, PMRC_ADDR_OSC_CONTROL, 32'h20);
    retire();
    chk(cpu_clk_en, 1'b0);
    wake_in.comparator_low <= 1'b1;
    wait_rst(1'b0);
    rchk(PMRC_ADDR_STATUS, 32'h7, 32'h0);
    wake_in.comparator_low <= 1'b0;
    // flash write with the low threshold, then with the high one
    pulse(2);
    wait_rst(1'b1);
    wait_rst(1'b0);
    rchk(PMRC_ADDR_RESET_SOURCE, 32'h42, 32'h40);
    apb(1'b1, PMRC_ADDR_SUPPLY_MONITOR, 32'ha0);
    apb(1'b1, PMRC_ADDR_RESET_SOURCE, 32'h2);
    rchk(PMRC_ADDR_RESET_SOURCE, 32'h2, 32'h0);
    pulse(2);
    repeat (8) @(posedge pclk);
    #1;
    chk(system_reset, 1'b0);
    // uncalibrated regulator at high threshold holds reset until power-on
    regulator_calibrated <= 1'b0;
    pulse(1);
    repeat (40) @(posedge pclk);
    #1;
    chk(system_reset, 1'b1);
    pulse(3);
    regulator_calibrated <= 1'b1;
    wait_rst(1'b0);
    rchk(PMRC_ADDR_SUPPLY_MONITOR, 32'ha0, 32'h80);
    rchk(PMRC_ADDR_RESET_SOURCE, 32'h2, 32'h2);
    // supply dip holds reset with the pin driven
    supply_below_threshold <= 1'b1;
    wait_rst(1'b1);
    repeat (20) @(posedge pclk);
    #1;
    chk({system_reset, reset_pin_oe}, 32'h3);
    supply_below_threshold <= 1'b0;
    wait_rst(1'b0);
    rchk(PMRC_ADDR_RESET_SOURCE, 32'h2, 32'h0);
    // monitor disabled, idle entry, then a plain reset
    apb(1'b1, PMRC_ADDR_SUPPLY_MONITOR, 32'h0);
    apb(1'b1, PMRC_ADDR_POWER_CONTROL, 32'h1);
    retire();
    chk({cpu_clk_en, periph_clk_en}, 32'h1);
    // an interrupt ends idle and is serviced at once
    wake_in.interrupt <= 1'b1;
    for (int n = 0; n < 20 && irq_service_req !== 1'b1; n++)
    begin
      @(posedge pclk);
      #1;
    end
    chk({irq_service_req, cpu_clk_en}, 32'h3);
    wake_in.interrupt <= 1'b0;
    pulse(1);
    wait_rst(1'b1);
    wait_rst(1'b0);
    rchk(PMRC_ADDR_SUPPLY_MONITOR, 32'h80, 32'h0);
    end_of_test();
  end
endmodule

// ### pmrc_pkg.sv
// package for the power mode and reset control block
package pmrc_pkg;
  // register byte addresses (index * 4 where printed offset is not word aligned)
  localparam logic [7:0]  PMRC_IDX_POWER_CONTROL   = 8'h87;
  localparam logic [11:0] PMRC_ADDR_POWER_CONTROL  = 12'h21c;
  localparam logic [11:0] PMRC_ADDR_OSC_CONTROL    = 12'h400;
  localparam logic [11:0] PMRC_ADDR_SUPPLY_MONITOR = 12'h404;
  localparam logic [11:0] PMRC_ADDR_RESET_SOURCE   = 12'h408;
  localparam logic [11:0] PMRC_ADDR_VREF_CONTROL   = 12'h40c;
  localparam logic [11:0] PMRC_ADDR_STATUS         = 12'h410;
  localparam logic [11:0] PMRC_ADDR_WAKE_CONTROL   = 12'h414;
  // field positions
  localparam int PMRC_BIT_IDLE       = 0;
  localparam int PMRC_BIT_STOP       = 1;
  localparam int PMRC_BIT_SUSPEND    = 5;
  localparam int PMRC_BIT_MON_EN     = 7;
  localparam int PMRC_BIT_MON_STAT   = 6;
  localparam int PMRC_BIT_THRESH     = 5;
  localparam int PMRC_BIT_PORF       = 1;
  localparam int PMRC_BIT_MCDF       = 2;
  localparam int PMRC_BIT_FLASHERR   = 6;
  localparam int PMRC_BIT_ZTC        = 3;
  localparam int PMRC_BIT_CMP_WAKE   = 0;
  localparam logic [7:0] PMRC_SCRATCH_MASK = 8'hfc;
  // reset values
  localparam logic [7:0] PMRC_RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] PMRC_PORT_LATCH_RESET  = 8'hff;
  localparam logic [15:0] PMRC_RESET_VECTOR     = 16'h0000;
  localparam logic [3:0] PMRC_WDT_DIV           = 4'hc;
  // timing
  localparam int PMRC_CLK_MHZ       = 100;
  localparam int PMRC_MCD_TIMEOUT_US = 100;
  localparam int PMRC_MCD_CYCLES    = PMRC_MCD_TIMEOUT_US * PMRC_CLK_MHZ;
  localparam int PMRC_SEQ_CYCLES    = 4;

  typedef enum logic [2:0] {
    PMRC_RUN, PMRC_IDLE_ST, PMRC_STOP_ST, PMRC_SUSP_ST, PMRC_RESET_ST
  } pmrc_state_t;

  // reset cause bundle
  typedef struct packed {
    logic power_on;
    logic supply_low;
    logic missing_clock;
    logic flash_error;
    logic other;
  } pmrc_cause_t;

  // wake events bundle
  typedef struct packed {
    logic port_match;
    logic comparator_low;
    logic interrupt;
  } pmrc_wake_t;
endpackage
